// File: inc/rfsd_pkg.sv
// package: constants, field layouts and types of the rf divider and power-down control
package rfsd_pkg;

	localparam int WORD_W = 24;
	localparam int N_W = 13;
	localparam int FD_W = 7;
	localparam int TOT_W = 20;

	// register-select codes carried in the low three bits of each word
	localparam logic [2:0] SEL_DIV_CFG = 3'h3;
	localparam logic [2:0] SEL_N_WORD = 3'h4;
	localparam logic [2:0] SEL_BOOST = 3'h5;
	localparam logic [2:0] SEL_MISC = 3'h6;
	localparam int SEL_LSB = 0;

	// field positions
	localparam int DIV_PRESC_BIT = 22;
	localparam int DIV_FD_LSB = 3;
	localparam int NW_PD_BIT = 23;
	localparam int NW_N_LSB = 10;
	localparam int NW_FN_LSB = 3;
	localparam int BOOST_ZERO_BIT = 23;
	localparam int BOOST_LSB = 3;
	localparam int MISC_PDM_BIT = 8;

	// reset values: divider word powered down with a legal high-prescaler ratio
	localparam logic [23:0] DIV_CFG_RST = 24'h400003;
	localparam logic [23:0] N_WORD_RST = 24'h814004;
	localparam logic [23:0] BOOST_RST = 24'h000005;
	localparam logic [23:0] MISC_RST = 24'h000006;

	// divide arithmetic and legal ranges
	localparam logic [N_W-1:0] LOW_N_MIN = 13'h0028;
	localparam logic [N_W-1:0] LOW_N_MAX = 13'h0FFF;
	localparam logic [N_W-1:0] HIGH_N_MIN = 13'h0050;
	localparam logic [N_W-1:0] HIGH_N_MAX = 13'h1FFF;
	localparam logic [N_W-1:0] LOW_N_FLOOR = 13'h0018;
	localparam logic [N_W-1:0] HIGH_N_FLOOR = 13'h0030;
	localparam logic [7:0] FD_ZERO_VALUE = 8'h80;

	localparam logic [1:0] OM_INTEGER = 2'h0;
	localparam logic [1:0] OM_FRACTIONAL = 2'h1;

	// split of the main divide word
	typedef struct packed {
		logic [8:0] coarse_count;
		logic [1:0] mid_swallow_count;
		logic [1:0] fine_swallow_count;
	} rfsd_ndiv_s;

	// boost / mode controls, bits 22:3 of the boost word
	typedef struct packed {
		logic [1:0] slip_reduction_ctrl;
		logic [1:0] synth_op_mode;
		logic [1:0] boost_pump_gain;
		logic [13:0] boost_timeout_count;
	} rfsd_boost_s;

	typedef enum logic [1:0] {
		PD_RUN,
		PD_WAIT_CP,
		PD_DOWN
	} rfsd_pd_e;

endpackage

// File: logic/rfsd_serial_rx.sv
// serial programming shifter: shifts on clock rises, presents the word on latch
`timescale 1ns/10ps
`default_nettype none
module rfsd_serial_rx (
	input wire logic mclk, // system clock
	input wire logic rst_sync_n, // synchronised reset, active low
	input wire logic shift_stb, // one-cycle pulse per serial clock rise
	input wire logic shift_bit, // synchronised serial data
	input wire logic latch_stb, // one-cycle pulse per latch rise
	output logic [rfsd_pkg::WORD_W-1:0] word_q, // last latched word
	output logic load_q // one-cycle pulse, word_q is new
);

	logic [rfsd_pkg::WORD_W-1:0] shreg_q;

	// msb first; never gated by power-down so words keep landing
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			shreg_q <= 24'h000000;
			word_q <= 24'h000000;
			load_q <= 1'b0;
		end else begin
			if (shift_stb) begin
				shreg_q <= {shreg_q[rfsd_pkg::WORD_W-2:0], shift_bit};
			end
			if (latch_stb) begin
				word_q <= shreg_q;
			end
			load_q <= latch_stb;
		end
	end

endmodule
`default_nettype wire

// File: logic/rfsd_top.sv
// rf feedback divider decode and power-down sequencing behind the serial port
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RULE1: low prescaler takes main_divide_word only from 40 to 4095.
// RULE2: high prescaler takes main_divide_word only from 80 to 8191.
// RULE3: ratio is prescaler times coarse, plus four times mid, plus fine.
// RULE4: high prescaler: the word is the plain binary divide ratio.
// RULE5: low prescaler: third lowest word bit is ignored in all divide math.
// RULE6: high prescaler: host never writes 0 to 47.
// RULE7: high prescaler 48..79: fractional mode only listed values, integer all.
// RULE8: low prescaler: host never writes 0 to 23.
// RULE9: low prescaler 24..39: fractional mode only listed values, integer all.
// RULE10: fractional mode uses the word directly; integer mode mixes numerator, denominator.
// RULE11: power-down stops feedback divider and floats its input.
// RULE12: power-down also stops the reference divider.
// RULE13: reference input floats only when rf and if both power down.
// RULE14: power-down three-states charge pump and phase comparator.
// RULE15: serial port keeps shifting and latching during power-down.
// RULE16: mode-select bit 8 of misc word picks sync or async power-down.
// RULE17: sync mode: power-down waits for the charge-pump pulse to finish.
// RULE18: async mode: power-down takes effect at once.
// RULE19: boost word layout: 0, slip, op mode, pump gain, timeout, select 101.
// RULE20: integer mode total is word times denominator plus numerator.
// RULE21: prescaler_select 0 is the eight family, 1 the sixteen family.
// RULE22: synth_op_mode 0 integer, 1 fractional, 2 and 3 reserved.
// RULE23: out-of-range word is flagged unsupported, never clamped.
module rfsd_top (
	input wire logic mclk, // 125 MHz system clock
	input wire logic rst_n, // async reset, active low
	input wire logic prog_clk, // serial programming clock pin
	input wire logic prog_data, // serial programming data pin
	input wire logic prog_latch, // serial latch enable pin
	input wire logic if_synth_powerdown, // if synthesizer power-down level
	input wire logic cp_event_done, // charge-pump pulse finished, one cycle
	output logic fb_div_enable_q, // feedback divider running
	output logic fb_input_hiz_q, // feedback input floated and debiased
	output logic ref_div_enable_q, // reference divider running
	output logic ref_osc_input_hiz_q, // reference input floated
	output logic cp_tristate_q, // charge pump and phase comparator off
	output logic prescaler_select_q, // 0 eight family, 1 sixteen family
	output rfsd_pkg::rfsd_ndiv_s ndiv_q, // counter fields in use
	output logic [rfsd_pkg::N_W-1:0] div_ratio_q, // main divide ratio
	output logic [rfsd_pkg::TOT_W-1:0] total_div_q, // complete divide value
	output logic frac_mode_q, // loop runs fractional-n
	output logic n_unsupported_q, // word illegal for prescaler and mode
	output rfsd_pkg::rfsd_boost_s boost_cfg_q // boost and mode controls
);

	logic [1:0] rst_pipe_q;
	logic rst_sync_n;
	logic [3:0] meta_q;
	logic [3:0] sync_q;
	logic [1:0] prev_q;
	logic [23:0] div_cfg_q;
	logic [23:0] n_word_q;
	logic [23:0] misc_q;
	logic [23:0] rx_word;
	logic rx_load;
	rfsd_pkg::rfsd_pd_e pd_state_q;
	rfsd_pkg::rfsd_pd_e pd_state_d;

	// reset release through two flops
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_q <= 2'h0;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe_q[1];

	// pin synchronisers; edge detect only looks at the second stage
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			meta_q <= 4'h0;
			sync_q <= 4'h0;
			prev_q <= 2'h0;
		end else begin
			meta_q <= {if_synth_powerdown, prog_latch, prog_data, prog_clk};
			sync_q <= meta_q;
			prev_q <= {sync_q[2], sync_q[0]};
		end
	end

	wire shift_stb = sync_q[0] & ~prev_q[0];
	wire latch_stb = sync_q[2] & ~prev_q[1];
	wire if_pd = sync_q[3];

	rfsd_serial_rx u_rx (
		.mclk(mclk),
		.rst_sync_n(rst_sync_n),
		.shift_stb(shift_stb),
		.shift_bit(sync_q[1]),
		.latch_stb(latch_stb),
		.word_q(rx_word),
		.load_q(rx_load)
	);

	wire [2:0] rx_sel = rx_word[rfsd_pkg::SEL_LSB +: 3];

	// register file, loaded whatever the power-down state
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			div_cfg_q <= rfsd_pkg::DIV_CFG_RST;
			n_word_q <= rfsd_pkg::N_WORD_RST;
			misc_q <= rfsd_pkg::MISC_RST;
			boost_cfg_q <= rfsd_pkg::BOOST_RST[22:3];
		end else if (rx_load) begin // RULE15
			if (rx_sel == rfsd_pkg::SEL_DIV_CFG) div_cfg_q <= rx_word;
			if (rx_sel == rfsd_pkg::SEL_N_WORD) n_word_q <= rx_word;
			if (rx_sel == rfsd_pkg::SEL_MISC) misc_q <= rx_word;
			if (rx_sel == rfsd_pkg::SEL_BOOST) boost_cfg_q <= rx_word[22:3]; // RULE19
		end
	end

	// field decode
	wire presc_high = div_cfg_q[rfsd_pkg::DIV_PRESC_BIT]; // RULE21
	wire [6:0] fd_raw = div_cfg_q[rfsd_pkg::DIV_FD_LSB +: rfsd_pkg::FD_W];
	wire [7:0] fd_val = (fd_raw == 7'h00) ? rfsd_pkg::FD_ZERO_VALUE : {1'b0, fd_raw};
	wire [12:0] n_word = n_word_q[rfsd_pkg::NW_N_LSB +: rfsd_pkg::N_W];
	wire [6:0] fn_val = n_word_q[rfsd_pkg::NW_FN_LSB +: rfsd_pkg::FD_W];
	wire pd_req = n_word_q[rfsd_pkg::NW_PD_BIT];
	wire pd_sync_mode = misc_q[rfsd_pkg::MISC_PDM_BIT]; // RULE16
	wire frac_mode = (boost_cfg_q.synth_op_mode == rfsd_pkg::OM_FRACTIONAL); // RULE22

	// low prescaler drops the third lowest bit from the mid field
	wire [1:0] mid_eff = presc_high ? n_word[3:2] : {n_word[3], 1'b0}; // RULE5
	wire [12:0] coarse_term = presc_high ? {n_word[12:4], 4'h0} : {1'b0, n_word[12:4], 3'h0};
	wire [12:0] ratio = coarse_term + {9'h000, mid_eff, 2'h0} + {11'h000, n_word[1:0]}; // RULE3 RULE4
	// widen before multiplying: a 13-bit product would wrap above 8191
	wire [19:0] int_total = 20'(ratio) * 20'(fd_val) + 20'(fn_val); // RULE20

	// legality check; gaps in the short span apply to fractional mode only
	function automatic logic ratio_legal(input logic [12:0] r, input logic hi, input logic fr);
		logic gap_ok;
		// each prescaler has its own list; the low list is not a scaled high list
		gap_ok = hi ?
			((r <= 13'h0031) || (r == 13'h0034) || (r == 13'h0035) ||
			((r >= 13'h0040) && (r[1:0] != 2'h3))) :
			((r <= 13'h0019) || (r == 13'h001C) || (r == 13'h001D) ||
			((r >= 13'h0020) && (r != 13'h0023) && (r != 13'h0027)));
		if (r < (hi ? rfsd_pkg::HIGH_N_FLOOR : rfsd_pkg::LOW_N_FLOOR)) begin
			return 1'b0;
		end else if (r < (hi ? rfsd_pkg::HIGH_N_MIN : rfsd_pkg::LOW_N_MIN)) begin
			return !fr || gap_ok;
		end else begin
			return r <= (hi ? rfsd_pkg::HIGH_N_MAX : rfsd_pkg::LOW_N_MAX);
		end
	endfunction
	wire legal = ratio_legal(ratio, presc_high, frac_mode); // RULE1 RULE2 RULE6 RULE7 RULE8 RULE9

	// divider outputs; an illegal word passes unchanged, only flagged
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prescaler_select_q <= 1'b0;
			ndiv_q <= '0;
			div_ratio_q <= 13'h0000;
			total_div_q <= 20'h00000;
			frac_mode_q <= 1'b0;
			n_unsupported_q <= 1'b0;
		end else begin
			prescaler_select_q <= presc_high;
			ndiv_q <= {n_word[12:4], mid_eff, n_word[1:0]};
			div_ratio_q <= ratio;
			total_div_q <= frac_mode ? {7'h00, ratio} : int_total; // RULE10
			frac_mode_q <= frac_mode;
			n_unsupported_q <= !legal; // RULE23
		end
	end

	// power-down sequencing; sync mode holds off until the pump pulse ends
	always_comb begin
		pd_state_d = pd_state_q;
		case (pd_state_q)
			rfsd_pkg::PD_RUN: begin
				if (pd_req && !pd_sync_mode) pd_state_d = rfsd_pkg::PD_DOWN; // RULE18
				else if (pd_req && cp_event_done) pd_state_d = rfsd_pkg::PD_DOWN; // RULE17
				else if (pd_req) pd_state_d = rfsd_pkg::PD_WAIT_CP;
			end
			rfsd_pkg::PD_WAIT_CP: begin
				if (!pd_req) pd_state_d = rfsd_pkg::PD_RUN;
				else if (cp_event_done || !pd_sync_mode) pd_state_d = rfsd_pkg::PD_DOWN; // RULE17
			end
			rfsd_pkg::PD_DOWN: begin
				if (!pd_req) pd_state_d = rfsd_pkg::PD_RUN;
			end
			default: pd_state_d = rfsd_pkg::PD_RUN;
		endcase
	end

	wire down_d = (pd_state_d == rfsd_pkg::PD_DOWN);

	// outputs follow the next state so they change with it
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pd_state_q <= rfsd_pkg::PD_DOWN;
			fb_div_enable_q <= 1'b0;
			fb_input_hiz_q <= 1'b1;
			ref_div_enable_q <= 1'b0;
			ref_osc_input_hiz_q <= 1'b0;
			cp_tristate_q <= 1'b1;
		end else begin
			pd_state_q <= pd_state_d;
			fb_div_enable_q <= !down_d; // RULE11
			fb_input_hiz_q <= down_d; // RULE11
			ref_div_enable_q <= !down_d; // RULE12
			ref_osc_input_hiz_q <= down_d && if_pd; // RULE13
			cp_tristate_q <= down_d; // RULE14
		end
	end

	// checks start one edge after release, once outputs have left their reset values
	logic chk_run_q;
	always_ff @(posedge mclk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			chk_run_q <= 1'b0;
		end else begin
			chk_run_q <= 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!chk_run_q);

	chk_async_pd_now: assert property ( // RULE18
		(pd_req && !pd_sync_mode) |=> cp_tristate_q && fb_input_hiz_q)
		else $error("async power-down not taken at once");
	chk_sync_pd_wait: assert property ( // RULE17
		(pd_req && pd_sync_mode && !cp_event_done && !cp_tristate_q) |=> !cp_tristate_q)
		else $error("sync power-down did not wait for pump");
	chk_sync_pd_enter: assert property ( // RULE17
		(pd_req && pd_sync_mode && cp_event_done) |=> !fb_div_enable_q)
		else $error("sync power-down missed pump end");
	chk_ref_follows_fb: assert property ( // RULE12
		ref_div_enable_q == fb_div_enable_q && cp_tristate_q == !fb_div_enable_q)
		else $error("reference divider out of step");
	chk_osc_both_pd: assert property ( // RULE13
		ref_osc_input_hiz_q |-> fb_input_hiz_q && $past(if_pd))
		else $error("reference input floated without both powered down");
	chk_ratio_high_word: assert property ( // RULE4
		presc_high |=> div_ratio_q == $past(n_word))
		else $error("high prescaler ratio differs from word");
	chk_ratio_low_bit: assert property ( // RULE5
		(!presc_high && $stable(n_word[12:3]) && $stable(n_word[1:0]) && $stable(presc_high))
		|=> $stable(div_ratio_q))
		else $error("ignored bit changed the low ratio");
	chk_int_total_mix: assert property ( // RULE20
		!frac_mode |=> total_div_q == 20'($past(ratio)) * 20'($past(fd_val)) + 20'($past(fn_val)))
		else $error("integer total mismatch");
	chk_frac_total_direct: assert property ( // RULE10
		frac_mode |=> total_div_q == {7'h00, $past(ratio)})
		else $error("fractional ratio mismatch");
	chk_boost_load_pd: assert property ( // RULE15 RULE19
		(rx_load && rx_sel == rfsd_pkg::SEL_BOOST) |=> boost_cfg_q == $past(rx_word[22:3]))
		else $error("boost word not latched");

	cov_sync_pd: cover property (pd_req && pd_sync_mode ##1 !cp_tristate_q ##1 cp_tristate_q);
	cov_async_pd: cover property (!cp_tristate_q ##1 pd_req && !pd_sync_mode ##1 cp_tristate_q);
	cov_load_in_pd: cover property (cp_tristate_q && rx_load);
	cov_osc_hiz: cover property (ref_osc_input_hiz_q);

endmodule
`default_nettype wire

// File: testbench/rfsd_host_model.sv
// host model: three-wire serial programming master for the rf divider block
`timescale 1ns/10ps
`default_nettype none
module rfsd_host_model (
	input wire logic mclk, // system clock
	output logic prog_clk, // serial clock, still between words
	output logic prog_data, // serial data, msb first
	output logic prog_latch // latch enable
);
	initial begin
		prog_clk = 1'b0;
		prog_data = 1'b0;
		prog_latch = 1'b0;
	end
	// four cycles per level, one above the minimum so sync jitter never eats it
	task automatic hold_lvl();
		repeat (4) @(posedge mclk);
		#1;
	endtask
	// one 24-bit word, msb first, then a latch pulse
	task automatic write_word(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			prog_data = w[i];
			hold_lvl();
			prog_clk = 1'b1;
			hold_lvl();
			prog_clk = 1'b0;
		end
		prog_latch = 1'b1;
		hold_lvl();
		prog_latch = 1'b0;
		prog_data = ~w[0]; // released line must not look like the last bit
		hold_lvl();
		hold_lvl();
	endtask
	// mode bit goes first, then the power-down word
	task automatic power_down(input logic sync_mode, input logic [23:0] nword);
		write_word({15'h0, sync_mode, 8'h06});
		write_word(nword);
	endtask
endmodule
`default_nettype wire

// File: testbench/rfsd_top_test.sv
// self-checking bench for the rf divider and power-down block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module rfsd_top_test;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic if_pd = 1'b0;
	logic cp_done = 1'b0;
	wire logic pclk, pdata, platch;
	logic fb_en, fb_hiz, ref_en, osc_hiz, cp_tri, presc, frac, unsup;
	rfsd_pkg::rfsd_ndiv_s ndiv;
	logic [12:0] ratio;
	logic [19:0] total;
	rfsd_pkg::rfsd_boost_s boost;
	int miscompares = 0;
	int total_checks = 0;
	// exp, prescaler, op mode, word; low-prescaler words give 8*word[12:4]+8*word[3]+word[1:0]
	localparam logic [15:0] TC [12] = '{16'hE032, 16'h6030, 16'hC02F, 16'h4032, 16'h5FFF,
		16'hA032, 16'h2030, 16'h0032, 16'h8010, 16'h0FFB, 16'h2031, 16'hE043};
	always #4 mclk = ~mclk;
	rfsd_host_model host (.mclk(mclk), .prog_clk(pclk), .prog_data(pdata), .prog_latch(platch));
	rfsd_top dut (.mclk(mclk), .rst_n(rst_n), .prog_clk(pclk), .prog_data(pdata),
		.prog_latch(platch), .if_synth_powerdown(if_pd), .cp_event_done(cp_done),
		.fb_div_enable_q(fb_en), .fb_input_hiz_q(fb_hiz), .ref_div_enable_q(ref_en),
		.ref_osc_input_hiz_q(osc_hiz), .cp_tristate_q(cp_tri), .prescaler_select_q(presc),
		.ndiv_q(ndiv), .div_ratio_q(ratio), .total_div_q(total), .frac_mode_q(frac),
		.n_unsupported_q(unsup), .boost_cfg_q(boost));
	function automatic logic [23:0] nw(input logic pd, input logic [12:0] n, input logic [6:0] fn);
		return {pd, n, fn, 3'h4};
	endfunction
	function automatic logic [23:0] dc(input logic p, input logic [6:0] fd);
		return {1'b0, p, 12'h000, fd, 3'h3};
	endfunction
	function automatic logic [23:0] bw(input logic [1:0] om);
		return {1'b0, 2'h2, om, 2'h3, 14'h1234, 3'h5};
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// all power-down outputs checked together, four against one expected level and osc_hiz against its own
	task automatic chk_pd(input logic dn, input logic osc);
		`CHK("fb_en", ~dn, fb_en)
		`CHK("fb_hiz", dn, fb_hiz)
		`CHK("ref_en", ~dn, ref_en)
		`CHK("osc_hiz", osc, osc_hiz)
		`CHK("cp_tri", dn, cp_tri)
	endtask
	task automatic stop_test();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// watchdog: a hung run counts as a mismatch
	initial begin
		repeat (100000) @(posedge mclk);
		miscompares++;
		stop_test();
	end
	initial begin
		cyc(10);
		rst_n = 1'b1;
		cyc(4);
		chk_pd(1'b1, 1'b0);
		`CHK("presc", 1'b1, presc)
		`CHK("ratio", 13'h0050, ratio)
		`CHK("total", 20'(80 * 128), total)
		`CHK("boost", 20'h00000, boost)
		// high prescaler, integer mode, powered up
		host.write_word(nw(1'b0, 13'h0051, 7'h05));
		chk_pd(1'b0, 1'b0);
		`CHK("ndiv", 13'h0051, ndiv)
		`CHK("total", 20'(81 * 128 + 5), total)
		// low prescaler: word bit 2 set but ignored
		host.write_word(dc(1'b0, 7'h0A));
		host.write_word(nw(1'b0, 13'h004D, 7'h03));
		`CHK("presc", 1'b0, presc)
		`CHK("ndiv", 13'h0049, ndiv)
		`CHK("ratio", 13'h0029, ratio)
		`CHK("total", 20'(41 * 10 + 3), total)
		host.write_word(bw(2'h1));
		`CHK("boost", {2'h2, 2'h1, 2'h3, 14'h1234}, boost)
		`CHK("total", 20'(41), total)
		for (int m = 0; m < 4; m++) begin
			host.write_word(bw(2'(m)));
			`CHK("frac", (m == 1), frac)
		end
		// legality table
		for (int i = 0; i < 12; i++) begin
			host.write_word(dc(TC[i][14], 7'h0A));
			host.write_word(bw({1'b0, TC[i][13]}));
			host.write_word(nw(1'b0, TC[i][12:0], 7'h00));
			`CHK("unsup", TC[i][15], unsup)
		end
		// asynchronous power-down with no charge-pump event
		if_pd = 1'b1;
		host.power_down(1'b0, nw(1'b1, 13'h0051, 7'h00));
		chk_pd(1'b1, 1'b1);
		host.write_word(bw(2'h1));
		`CHK("boost", {2'h2, 2'h1, 2'h3, 14'h1234}, boost)
		if_pd = 1'b0;
		cyc(4);
		chk_pd(1'b1, 1'b0);
		host.write_word(nw(1'b0, 13'h0051, 7'h00));
		chk_pd(1'b0, 1'b0);
		// synchronous power-down waits for the pump pulse
		host.power_down(1'b1, nw(1'b1, 13'h0051, 7'h00));
		chk_pd(1'b0, 1'b0);
		cp_done = 1'b1;
		cyc(1);
		cp_done = 1'b0;
		cyc(2);
		chk_pd(1'b1, 1'b0);
		stop_test();
	end
endmodule
`default_nettype wire
